// [hdl/remote_mode_pkg.sv]
// Purpose: constants and types for the remote mode controller
// Assumes: 125 MHz system clock, 32-bit APB
// Notes:   hold thresholds in ms, cycle counts derived
package remote_mode_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned HOLD_ON_MS  = 1000;
  localparam int unsigned HOLD_OFF_MS = 2000;
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned HOLD_ON_CYC  = HOLD_ON_MS * CYC_PER_MS;
  localparam int unsigned HOLD_OFF_CYC = HOLD_OFF_MS * CYC_PER_MS;
  localparam int unsigned BLINK_CYC    = BLINK_MS * CYC_PER_MS;

  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STANDBY_OFS = 8'h04;
  localparam logic [7:0] PSAVE_OFS   = 8'h08;
  localparam logic [7:0] CUTOFF_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;

  localparam int CTRL_RSTSEQ_BIT = 0;
  localparam int CTRL_STSEQ_BIT  = 1;
  localparam int CTRL_CUTOFF_BIT = 2;

  localparam logic [2:0]  CTRL_RST    = 3'h0;
  localparam logic [31:0] STANDBY_RST = 32'h0773_5940;
  localparam logic [31:0] PSAVE_RST   = 32'h0EE6_B280;
  localparam logic [31:0] CUTOFF_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    M_OFF   = 3'b000,
    M_DISC  = 3'b001,
    M_STOP  = 3'b010,
    M_START = 3'b011,
    M_HALT  = 3'b100,
    M_DIAG  = 3'b101
  } mode_t;

  typedef enum logic [1:0] {
    B_NONE  = 2'b00,
    B_START = 2'b01,
    B_COMBO = 2'b10,
    B_STOP  = 2'b11
  } btn_class_t;
endpackage : remote_mode_pkg

// [hdl/remote_mode_controller.sv]
// Purpose: operating-mode controller of a crane remote and its base relays
// Assumes: buttons and link flags synchronous to ref_clk
// Notes:   timeouts latched from registers at power-on
`timescale 1ns/10ps
`default_nettype none
// Function
// - power on when start button alone held longer than 1 s while off
// - after power-on run discovery, enter STOP when link found
// - start plus trigger held at least 1 s at power-on enters diagnostics
// - power off on low battery or power-saving timeout
// - halt button forces emergency halt from STOP or START
// - in halt, motion, safety and start relays are off
// - halt is honoured only while the halt indicator is lit
// - in halt, start indicator off and halt indicator blinks
// - leave halt: release, optional reset sequence, trigger, then STOP
// - in halt and STOP, status and power LEDs lit, link LED blinks
// - stop button in START goes to STOP
// - no button for longer than standby timeout goes to STOP
// - loss of the wireless link forces STOP
// - STOP entry: motion off, delayed cutoff after delay, then safety off
// - in STOP, motion disabled, safety and start relays off
// - in STOP the radio link relay stays on
// - STOP: start indicator off or reverse flash, halt indicator lit
// - from STOP only START, halt, power off or charging are allowed
// - only START accepts motion and horn and switches safety relays on
// - from STOP, stop button alone held over 2 s powers off
// - no button for standby plus power-saving timeout powers off
module remote_mode_controller
  import remote_mode_pkg::*;
#(
  parameter int unsigned HOLD_ON  = remote_mode_pkg::HOLD_ON_CYC,
  parameter int unsigned HOLD_OFF = remote_mode_pkg::HOLD_OFF_CYC,
  parameter int unsigned BLINK    = remote_mode_pkg::BLINK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        startBtn,
  input  wire logic        stopBtn,
  input  wire logic        triggerBtn,
  input  wire logic        haltBtn,
  input  wire logic        motionAny,
  input  wire logic        resetSeqOk,
  input  wire logic        startSeqOk,
  input  wire logic        linkFound,
  input  wire logic        linkLost,
  input  wire logic        batteryLow,
  input  wire logic        charging,
  output var  logic        remoteOn,
  output var  logic        diagMode,
  output var  logic        motionRelay,
  output var  logic        hornRelay,
  output var  logic        delayed_cutoff_relays,
  output var  logic        safetyRelay,
  output var  logic        startRelay,
  output var  logic        radioLinkRelay,
  output var  logic        startLed,
  output var  logic        haltLed,
  output var  logic        system_ok_led,
  output var  logic        powerLed,
  output var  logic        link_activity_led
);
  import remote_mode_pkg::*;

  if (HOLD_ON < 2 || HOLD_OFF < 2 || BLINK < 1) begin : g_chk
    $error("hold and blink counts too small");
  end

  // register file
  logic [2:0]  ctrl_reg;
  logic [31:0] standby_reg, psave_reg, cutoff_reg;
  logic [31:0] cfgStandby_reg, cfgPsave_reg, cfgCutoff_reg;
  logic [2:0]  cfgCtrl_reg;
  logic        wrEn, mapped;
  logic [31:0] rdVal;

  mode_t       mode_reg, mode_next;
  btn_class_t  cls, cls_reg;
  logic [31:0] hold_reg, idle_reg, cut_reg;
  logic [32:0] offLimit;
  logic        shut_reg, blink_reg, rel_reg, seq_reg;
  logic [31:0] blinkCnt_reg;
  logic        others, anyBtn, haltOk;

  assign mapped = (paddr == CTRL_OFS) || (paddr == STANDBY_OFS) ||
                  (paddr == PSAVE_OFS) || (paddr == CUTOFF_OFS) ||
                  (paddr == STATUS_OFS);
  assign wrEn = psel && penable && pready && pwrite && mapped &&
                (paddr != STATUS_OFS);

  always_comb begin
    unique case (paddr)
      CTRL_OFS:    rdVal = {29'h0, ctrl_reg};
      STANDBY_OFS: rdVal = standby_reg;
      PSAVE_OFS:   rdVal = psave_reg;
      CUTOFF_OFS:  rdVal = cutoff_reg;
      STATUS_OFS:  rdVal = {16'h0000, 3'h0, shut_reg, motionRelay,
                            delayed_cutoff_relays, safetyRelay, startRelay,
                            radioLinkRelay, startLed, haltLed,
                            link_activity_led, 1'b0, mode_reg};
      default:     rdVal = 32'h0000_0000;
    endcase
  end

  // apb: one wait-free access phase, answer prepared in setup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && paddr == STATUS_OFS));
      prdata  <= (psel && !penable && !pwrite) ? rdVal : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg    <= CTRL_RST;
      standby_reg <= STANDBY_RST;
      psave_reg   <= PSAVE_RST;
      cutoff_reg  <= CUTOFF_RST;
    end else if (wrEn) begin
      unique case (paddr)
        CTRL_OFS:    ctrl_reg    <= pwdata[2:0];
        STANDBY_OFS: standby_reg <= pwdata;
        PSAVE_OFS:   psave_reg   <= pwdata;
        default:     cutoff_reg  <= pwdata;
      endcase
    end
  end

  // configuration latched when the remote powers on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfgCtrl_reg    <= CTRL_RST;
      cfgStandby_reg <= STANDBY_RST;
      cfgPsave_reg   <= PSAVE_RST;
      cfgCutoff_reg  <= CUTOFF_RST;
    end else if (mode_reg == M_OFF) begin
      cfgCtrl_reg    <= ctrl_reg;
      cfgStandby_reg <= standby_reg;
      cfgPsave_reg   <= psave_reg;
      cfgCutoff_reg  <= cutoff_reg;
    end
  end

  // button classes and hold counter
  assign others = stopBtn || triggerBtn || haltBtn || motionAny;
  assign anyBtn = startBtn || others;
  always_comb begin
    if (startBtn && !others)
      cls = B_START;
    else if (startBtn && triggerBtn && !stopBtn && !haltBtn && !motionAny)
      cls = B_COMBO;
    else if (stopBtn && !startBtn && !triggerBtn && !haltBtn && !motionAny)
      cls = B_STOP;
    else
      cls = B_NONE;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cls_reg  <= B_NONE;
      hold_reg <= 32'h0000_0000;
    end else begin
      cls_reg <= cls;
      if (cls == B_NONE || mode_next != mode_reg)
        hold_reg <= 32'h0000_0000;
      else if (cls != cls_reg)
        hold_reg <= 32'h0000_0001;
      else if (hold_reg != 32'hFFFF_FFFF)
        hold_reg <= hold_reg + 32'h0000_0001;
    end
  end

  // idle time since last press
  assign offLimit = {1'b0, cfgStandby_reg} + {1'b0, cfgPsave_reg};
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      idle_reg <= 32'h0000_0000;
    else if (anyBtn || mode_reg == M_OFF)
      idle_reg <= 32'h0000_0000;
    else if (idle_reg != 32'hFFFF_FFFF)
      idle_reg <= idle_reg + 32'h0000_0001;
  end

  // halt release bookkeeping
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rel_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else if (mode_reg != M_HALT) begin
      rel_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else begin
      if (!haltBtn)
        rel_reg <= 1'b1;
      if (rel_reg && resetSeqOk)
        seq_reg <= 1'b1;
    end
  end

  assign haltOk = haltLed;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      M_OFF: begin
        if (cls == B_COMBO && hold_reg == HOLD_ON)
          mode_next = M_DIAG;
        else if (cls == B_START && hold_reg == HOLD_ON + 1)
          mode_next = M_DISC;
      end
      M_DISC: begin
        if (batteryLow || {1'b0, idle_reg} > offLimit)
          mode_next = M_OFF;
        else if (linkFound)
          mode_next = M_STOP;
      end
      M_DIAG: begin
        if (batteryLow || (cls == B_STOP && hold_reg == HOLD_OFF + 1))
          mode_next = M_OFF;
      end
      M_STOP: begin
        if (haltBtn && haltOk)
          mode_next = M_HALT;
        else if (batteryLow || charging || {1'b0, idle_reg} > offLimit)
          mode_next = M_OFF;
        else if (cls == B_STOP && hold_reg == HOLD_OFF + 1)
          mode_next = M_OFF;
        else if (cls == B_START && hold_reg == HOLD_ON + 1 &&
                 (startSeqOk || !cfgCtrl_reg[CTRL_STSEQ_BIT]))
          mode_next = M_START;
      end
      M_START: begin
        if (haltBtn && haltOk)
          mode_next = M_HALT;
        else if (batteryLow)
          mode_next = M_OFF;
        else if (stopBtn || linkLost || idle_reg > cfgStandby_reg)
          mode_next = M_STOP;
      end
      M_HALT: begin
        if (batteryLow)
          mode_next = M_OFF;
        else if (rel_reg && !haltBtn && triggerBtn &&
                 (seq_reg || !cfgCtrl_reg[CTRL_RSTSEQ_BIT]))
          mode_next = M_STOP;
      end
      default: mode_next = M_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      mode_reg <= M_OFF;
    else
      mode_reg <= mode_next;
  end

  // shutdown order on leaving START for STOP
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shut_reg <= 1'b0;
      cut_reg  <= 32'h0000_0000;
    end else if (mode_reg == M_START && mode_next == M_STOP) begin
      shut_reg <= 1'b1;
      cut_reg  <= cfgCtrl_reg[CTRL_CUTOFF_BIT] ? cfgCutoff_reg : 32'h0000_0000;
    end else if (mode_reg != M_STOP || mode_next != M_STOP) begin
      shut_reg <= 1'b0;
      cut_reg  <= 32'h0000_0000;
    end else if (cut_reg != 32'h0000_0000) begin
      cut_reg <= cut_reg - 32'h0000_0001;
    end else begin
      shut_reg <= 1'b0;
    end
  end

  // blink divider
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg    <= 1'b0;
    end else if (blinkCnt_reg == BLINK - 1) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg    <= !blink_reg;
    end else begin
      blinkCnt_reg <= blinkCnt_reg + 32'h0000_0001;
    end
  end

  // relays
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      motionRelay           <= 1'b0;
      hornRelay             <= 1'b0;
      delayed_cutoff_relays <= 1'b0;
      safetyRelay           <= 1'b0;
      startRelay            <= 1'b0;
      radioLinkRelay        <= 1'b0;
    end else begin
      motionRelay <= mode_reg == M_START && motionAny;
      hornRelay   <= mode_reg == M_START && startBtn;
      delayed_cutoff_relays <= cfgCtrl_reg[CTRL_CUTOFF_BIT] &&
        (mode_reg == M_START || (shut_reg && cut_reg != 32'h0000_0000));
      safetyRelay <= mode_reg == M_START || shut_reg;
      startRelay  <= mode_reg == M_START;
      radioLinkRelay <= mode_reg == M_STOP || mode_reg == M_START ||
                        mode_reg == M_HALT;
    end
  end

  // indicators
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      startLed          <= 1'b0;
      haltLed           <= 1'b0;
      system_ok_led     <= 1'b0;
      powerLed          <= 1'b0;
      link_activity_led <= 1'b0;
      remoteOn          <= 1'b0;
      diagMode          <= 1'b0;
    end else begin
      unique case (mode_reg)
        M_START: startLed <= 1'b1;
        M_STOP:  startLed <= cfgCtrl_reg[CTRL_STSEQ_BIT] && !blink_reg;
        default: startLed <= 1'b0;
      endcase
      unique case (mode_reg)
        M_STOP, M_START: haltLed <= 1'b1;
        M_HALT:          haltLed <= blink_reg;
        default:         haltLed <= 1'b0;
      endcase
      system_ok_led     <= 1'b1;
      powerLed          <= 1'b1;
      link_activity_led <= mode_reg != M_OFF && mode_reg != M_DIAG &&
                           blink_reg;
      remoteOn <= mode_reg != M_OFF;
      diagMode <= mode_reg == M_DIAG;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_haltRelays;
    (mode_reg == M_HALT)[*2] |-> !motionRelay && !safetyRelay && !startRelay;
  endproperty
  a_haltRelays: assert property (p_haltRelays) else $error("relay on in halt");
  property p_haltEntry;
    (mode_reg inside {M_STOP, M_START}) && haltBtn && haltLed |=> mode_reg == M_HALT;
  endproperty
  a_haltEntry: assert property (p_haltEntry) else $error("halt not taken");
  property p_stopBtn;
    mode_reg == M_START && stopBtn && !haltBtn && !batteryLow |=> mode_reg == M_STOP;
  endproperty
  a_stopBtn: assert property (p_stopBtn) else $error("stop button ignored");
  property p_linkLost;
    mode_reg == M_START && linkLost && !haltBtn && !batteryLow |=> mode_reg == M_STOP;
  endproperty
  a_linkLost: assert property (p_linkLost) else $error("link loss ignored");
  property p_order;
    $fell(safetyRelay) && mode_reg == M_STOP |-> !delayed_cutoff_relays && !motionRelay;
  endproperty
  a_order: assert property (p_order) else $error("safety off too early");
  property p_stopLink;
    (mode_reg == M_STOP)[*2] |-> radioLinkRelay && haltLed && !startRelay;
  endproperty
  a_stopLink: assert property (p_stopLink) else $error("stop outputs wrong");
  property p_offAll;
    (mode_reg == M_OFF)[*2] |-> !radioLinkRelay && !link_activity_led && !safetyRelay;
  endproperty
  a_offAll: assert property (p_offAll) else $error("outputs on while off");
  property p_disc;
    mode_reg == M_DISC && linkFound && !batteryLow && {1'b0, idle_reg} <= offLimit
      |=> mode_reg == M_STOP;
  endproperty
  a_disc: assert property (p_disc) else $error("discovery not ended");
  property p_powerOn;
    mode_reg == M_OFF ##1 mode_reg == M_DISC |-> $past(startBtn) && $past(hold_reg) == HOLD_ON + 1;
  endproperty
  a_powerOn: assert property (p_powerOn) else $error("power on too soon");
  c_start: cover property (mode_reg == M_STOP ##1 mode_reg == M_START);
  c_halt:  cover property (mode_reg == M_HALT ##1 mode_reg == M_STOP);
  c_diag:  cover property (mode_reg == M_OFF ##1 mode_reg == M_DIAG);
  c_off:   cover property (mode_reg == M_STOP ##1 mode_reg == M_OFF);
endmodule : remote_mode_controller
`default_nettype wire

// [verif/operator_panel_model.sv]
// Purpose: operator panel stand-in driving buttons, link and battery flags
// Assumes: levels change by non-blocking assignment after a rising edge
// Notes:   bit order startBtn,stopBtn,trigger,halt,motion,rstSeq,stSeq,found,lost,batt,chg
`timescale 1ns/10ps
`default_nettype none
module operator_panel_model (
  input  wire logic        ref_clk,
  output var  logic [10:0] panel
);
  initial panel = 11'h000;

  task automatic apply(input logic [10:0] v);
    @(posedge ref_clk);
    panel <= v;
  endtask : apply

  // halt exit: halt released first, optional sequence, then trigger
  task automatic halt_exit(input logic [10:0] base, input logic seq);
    apply(base);
    if (seq) apply(base | 11'h020);
    apply(base);
    apply(base | 11'h100);
    apply(base);
  endtask : halt_exit
endmodule : operator_panel_model
`default_nettype wire

// [verif/remote_mode_controller_tb_top.sv]
// Purpose: self-checking bench for the remote mode controller
// Assumes: short hold counts via parameters, APB answers in one access cycle
// Notes:   mode is read back through the status register
`timescale 1ns/10ps
`default_nettype none
module remote_mode_controller_tb_top;
  import remote_mode_pkg::*;
  localparam int unsigned HON  = 20;
  localparam int unsigned HOFF = 40;
  localparam int unsigned BLK  = 4;
  localparam int unsigned STBY = 300;
  localparam int unsigned PSV  = 300;
  localparam int unsigned CUT  = 6;
  localparam logic [10:0] K_START = 11'h400;
  localparam logic [10:0] K_STOP  = 11'h200;
  localparam logic [10:0] K_TRIG  = 11'h100;
  localparam logic [10:0] K_HALT  = 11'h080;
  localparam logic [10:0] K_MOT   = 11'h040;
  localparam logic [10:0] K_SEQ   = 11'h010;
  localparam logic [10:0] K_FOUND = 11'h008;
  localparam logic [10:0] K_LOST  = 11'h004;
  localparam logic [10:0] K_BATT  = 11'h002;
  localparam logic [10:0] K_CHG   = 11'h001;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [10:0] panel, base;
  logic remoteOn, diagMode, motionRelay, hornRelay, cutRly, safetyRelay, startRelay;
  logic radioLinkRelay, startLed, haltLed, okLed, powerLed, linkLed;
  int mismatches = 0;
  int checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  operator_panel_model u_operator_panel_model (.ref_clk(ref_clk), .panel(panel));

  remote_mode_controller #(.HOLD_ON(HON), .HOLD_OFF(HOFF), .BLINK(BLK)) u_remote_mode_controller (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startBtn(panel[10]), .stopBtn(panel[9]), .triggerBtn(panel[8]), .haltBtn(panel[7]),
    .motionAny(panel[6]), .resetSeqOk(panel[5]), .startSeqOk(panel[4]),
    .linkFound(panel[3]), .linkLost(panel[2]), .batteryLow(panel[1]), .charging(panel[0]),
    .remoteOn(remoteOn), .diagMode(diagMode), .motionRelay(motionRelay),
    .hornRelay(hornRelay), .delayed_cutoff_relays(cutRly), .safetyRelay(safetyRelay),
    .startRelay(startRelay), .radioLinkRelay(radioLinkRelay), .startLed(startLed),
    .haltLed(haltLed), .system_ok_led(okLed), .powerLed(powerLed),
    .link_activity_led(linkLed));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  // one APB transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      chk("pready timeout", 1, 0);
      end_sim();
    end
  endtask : apb

  task automatic wait_mode(input mode_t m, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      if (rd[2:0] === m) break;
    end
    chk("mode", m, rd[2:0]);
    if (i >= bound) end_sim();
    repeat (3) @(posedge ref_clk);
  endtask : wait_mode

  task automatic hold(input logic [10:0] v, input int n);
    u_operator_panel_model.apply(v);
    repeat (n) @(posedge ref_clk);
    u_operator_panel_model.apply(base);
  endtask : hold

  task automatic power_on;
    base = 11'h000;
    hold(K_START, HON + 5);
    wait_mode(M_DISC, 20);
    base = K_FOUND;
    u_operator_panel_model.apply(base);
    wait_mode(M_STOP, 20);
  endtask : power_on

  task automatic to_start;
    hold(base | K_START, HON + 5);
    wait_mode(M_START, 20);
  endtask : to_start

  task automatic t_regs;
    logic [7:0] ofs [4] = '{CTRL_OFS, STANDBY_OFS, PSAVE_OFS, CUTOFF_OFS};
    logic [31:0] rv [4] = '{32'h0000_0000, STANDBY_RST, PSAVE_RST, CUTOFF_RST};
    logic [31:0] nv [4] = '{32'h0000_0005, STBY, PSV, CUT};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk("reset value", rv[i], rd);
      apb(1'b1, ofs[i], nv[i]);
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk("readback", nv[i], rd);
    end
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped error", 1, err);
    apb(1'b1, STATUS_OFS, 32'h0000_0003);
    chk("status write error", 1, err);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("mode after reset", M_OFF, rd[2:0]);
  endtask : t_regs

  task automatic t_power_on;
    base = 11'h000;
    hold(K_HALT, 5);
    hold(K_START, HON - 10);
    repeat (3) @(posedge ref_clk);
    chk("short hold stays off", 0, remoteOn);
    power_on();
    chk("radio link relay", 1, radioLinkRelay);
    chk("stop safety", 0, safetyRelay);
    chk("stop start relay", 0, startRelay);
    chk("stop horn", 0, hornRelay);
    chk("stop start led", 0, startLed);
    chk("stop halt led", 1, haltLed);
    chk("ok and power led", 2'b11, {okLed, powerLed});
  endtask : t_power_on

  task automatic t_shutdown_order;
    int mOff, cOff, sOff;
    to_start();
    u_operator_panel_model.apply(base | K_MOT | K_START);
    repeat (3) @(posedge ref_clk);
    chk("start safety", 1, safetyRelay);
    chk("horn relay", 1, hornRelay);
    chk("motion relay", 1, motionRelay);
    hold(base | K_MOT | K_STOP, 1);
    mOff = -1; cOff = -1; sOff = -1;
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (mOff < 0 && motionRelay === 1'b0) mOff = i;
      if (cOff < 0 && cutRly === 1'b0) cOff = i;
      if (sOff < 0 && safetyRelay === 1'b0) sOff = i;
    end
    chk("motion drops first", 1, mOff >= 0 && mOff < cOff);
    chk("cutoff delay kept", 1, cOff - mOff >= CUT);
    chk("safety after cutoff", cOff + 1, sOff);
    wait_mode(M_STOP, 5);
  endtask : t_shutdown_order

  task automatic t_halt;
    logic b0, l0, hc, lc;
    to_start();
    hold(base | K_HALT, 4);
    u_operator_panel_model.apply(base | K_HALT);
    wait_mode(M_HALT, 5);
    chk("halt relays", 3'b000, {safetyRelay, motionRelay, startRelay});
    chk("halt start led", 0, startLed);
    chk("halt ok power", 2'b11, {okLed, powerLed});
    b0 = haltLed;
    l0 = linkLed;
    hc = 1'b0;
    lc = 1'b0;
    repeat (2 * BLK + 2) begin
      @(posedge ref_clk);
      if (haltLed !== b0) hc = 1'b1;
      if (linkLed !== l0) lc = 1'b1;
    end
    chk("halt led blinks", 1, hc);
    chk("link led blinks", 1, lc);
    hold(base | K_HALT | K_TRIG, 3);
    u_operator_panel_model.halt_exit(base, 1'b0);
    wait_mode(M_HALT, 3);
    u_operator_panel_model.halt_exit(base, 1'b1);
    wait_mode(M_STOP, 10);
  endtask : t_halt

  task automatic t_link_idle;
    to_start();
    hold(base | K_LOST, 2);
    wait_mode(M_STOP, 10);
    to_start();
    repeat (STBY / 2) @(posedge ref_clk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("still started", M_START, rd[2:0]);
    wait_mode(M_STOP, 100);
  endtask : t_link_idle

  task automatic t_off_paths;
    hold(base | K_STOP, HOFF + 5);
    wait_mode(M_OFF, 10);
    chk("off relays", 4'b0000, {remoteOn, radioLinkRelay, safetyRelay, linkLed});
    power_on();
    hold(base | K_CHG, 3);
    wait_mode(M_OFF, 10);
    power_on();
    wait_mode(M_OFF, 400);
    base = 11'h000;
    hold(K_START | K_TRIG, HON + 5);
    wait_mode(M_DIAG, 10);
    chk("diag flag", 1, diagMode);
    hold(K_BATT, 3);
    wait_mode(M_OFF, 10);
  endtask : t_off_paths

  task automatic t_start_access;
    logic s0, s1;
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    power_on();
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (2 * BLK + 2) begin
      @(posedge ref_clk);
      if (startLed === 1'b0) s0 = 1'b1;
      if (startLed === 1'b1) s1 = 1'b1;
    end
    chk("reverse flash", 2'b11, {s1, s0});
    hold(base | K_START, HON + 5);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("start without access", M_STOP, rd[2:0]);
    hold(base | K_START | K_SEQ, HON + 5);
    wait_mode(M_START, 20);
  endtask : t_start_access

  initial begin
    base = 11'h000;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_power_on();
    t_shutdown_order();
    t_halt();
    t_link_idle();
    t_off_paths();
    t_start_access();
    end_sim();
  end
endmodule : remote_mode_controller_tb_top
`default_nettype wire
